// >>> rtl/pdrh_pkg.sv
//----------------------------------------------------------------------------
// Purpose: Shared constants for the programmable divider with reset and hold
// Assumes: 32-bit AXI4-Lite register bus, 100 MHz aclk
// Notes:   Offsets are byte addresses of aligned 32-bit words
//----------------------------------------------------------------------------
package pdrh_pkg;

    //------------------------------------------------------------------------
    // Widths
    //------------------------------------------------------------------------
    localparam int RATIO_W = 32;
    localparam int ADDR_W  = 5;
    localparam int DATA_W  = 32;

    //------------------------------------------------------------------------
    // Register map
    //------------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFF_RATIO   = 5'h00;   // Active ratio, read only
    localparam logic [ADDR_W-1:0] OFF_SHIFT   = 5'h04;   // Serial shift image, read only
    localparam logic [ADDR_W-1:0] OFF_STATUS  = 5'h08;   // Live control and output levels
    localparam logic [ADDR_W-1:0] OFF_CONTROL = 5'h0C;   // Software reset and hold
    localparam logic [ADDR_W-1:0] OFF_COUNT   = 5'h10;   // Core counter, read only

    //------------------------------------------------------------------------
    // Field positions
    //------------------------------------------------------------------------
    localparam int CTL_RESET_BIT  = 0;
    localparam int CTL_FREEZE_BIT = 1;
    localparam int STA_RESET_BIT  = 0;
    localparam int STA_FREEZE_BIT = 1;
    localparam int STA_POS_BIT    = 2;
    localparam int STA_NEG_BIT    = 3;

    //------------------------------------------------------------------------
    // Reset values and responses
    //------------------------------------------------------------------------
    localparam logic [RATIO_W-1:0] RATIO_RESET   = 32'h0000_0000;
    localparam logic [1:0]         CONTROL_RESET = 2'h0;
    localparam logic [1:0]         RESP_OKAY     = 2'h0;
    localparam logic [1:0]         RESP_SLVERR   = 2'h2;

endpackage

// >>> rtl/pdrh_sync.sv
//----------------------------------------------------------------------------
// Purpose: Two-flop synchroniser for a group of asynchronous inputs
// Assumes: Inputs change slowly against aclk
// Notes:   Only the second stage leaves the module
//----------------------------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none

module pdrh_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } pdrh_sync_state_t;

    pdrh_sync_state_t st;
    pdrh_sync_state_t next_st;

    // Shift the inputs through two stages
    always_comb begin
        next_st        = st;
        next_st.meta   = async_in;
        next_st.stable = st.meta;
        if (!aresetn) begin
            next_st = '0;
        end
    end

    // State register
    always_ff @(posedge aclk) begin
        st <= next_st;
    end

    assign sync_out = st.stable;

endmodule

`default_nettype wire

// >>> rtl/pdrh_top.sv
//----------------------------------------------------------------------------
// Purpose: Programmable integer divider with reset, output freeze and serial
//          ratio loading, plus an AXI4-Lite window onto its state
// Assumes: All pins asynchronous to aclk; the high-speed input is far slower
//          than aclk so every edge is seen
// Notes:   Pin controls and software controls are ORed together
//----------------------------------------------------------------------------
//
// Design decisions made here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - Reset clears divider state, stops counting
// - Reset drives positive output low, negative high
// - Freeze holds outputs, counter keeps running
// - Reset and freeze never touch stored ratio
// - Control inputs active high, default low
// - Power-of-two ratio gives equal high, low
// - Duty stays within one third to two thirds
// - Pulse width is N minus power term
// - Ratios two to sixteen follow table widths
// - Ratio is 32-bit unsigned binary weighted
module pdrh_top #(
    parameter int RATIO_W = pdrh_pkg::RATIO_W
) (
    input  wire logic                        aclk,
    input  wire logic                        aresetn,
    // Divider pins
    input  wire logic                        div_in,
    input  wire logic                        div_reset_ctl,
    input  wire logic                        output_freeze_ctl,
    input  wire logic                        ratio_serial_in,
    input  wire logic                        ratio_shift_clk,
    input  wire logic                        ratio_load_strobe,
    output logic                             div_out_pos,
    output logic                             div_out_neg,
    // AXI4-Lite slave
    input  wire logic [pdrh_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]                  s_axi_awprot,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    input  wire logic [pdrh_pkg::DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    output logic [1:0]                       s_axi_bresp,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    input  wire logic [pdrh_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]                  s_axi_arprot,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    output logic [pdrh_pkg::DATA_W-1:0]      s_axi_rdata,
    output logic [1:0]                       s_axi_rresp,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready
);

    //------------------------------------------------------------------------
    // State
    //------------------------------------------------------------------------
    typedef struct packed {
        // Bus side
        logic                        aw_got;
        logic [pdrh_pkg::ADDR_W-1:0] aw_addr;
        logic                        w_got;
        logic [1:0]                  w_ctl;
        logic                        w_lane0;
        logic                        bvalid;
        logic [1:0]                  bresp;
        logic                        rvalid;
        logic [pdrh_pkg::DATA_W-1:0] rdata;
        logic [1:0]                  rresp;
        logic [1:0]                  control;
        // Serial link
        logic                        sclk_prev;
        logic                        load_prev;
        logic [RATIO_W-1:0]          shift_img;
        logic [RATIO_W-1:0]          ratio;
        logic [RATIO_W-1:0]          pulse_w;
        // Divider core
        logic                        in_prev;
        logic [RATIO_W-1:0]          cnt;
        logic                        out_pos;
        logic                        out_neg;
    } pdrh_state_t;

    pdrh_state_t st;
    pdrh_state_t next_st;

    //------------------------------------------------------------------------
    // Pin synchronisers
    //------------------------------------------------------------------------
    logic [5:0] pins_async;
    logic [5:0] pins_sync;
    logic       in_lvl;
    logic       rst_pin;
    logic       frz_pin;
    logic       sdat;
    logic       sclk;
    logic       sload;

    // Pins are active high; an idle low pin leaves everything enabled
    assign pins_async = {div_in, div_reset_ctl, output_freeze_ctl,
                         ratio_serial_in, ratio_shift_clk, ratio_load_strobe};

    pdrh_sync #(
        .WIDTH (6)
    ) u_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in (pins_async),
        .sync_out (pins_sync)
    );

    assign {in_lvl, rst_pin, frz_pin, sdat, sclk, sload} = pins_sync;

    //------------------------------------------------------------------------
    // Pulse width from ratio
    //------------------------------------------------------------------------
    // Width is N minus largest power p with 3p <= 2N
    function automatic logic [RATIO_W-1:0] pulse_width(input logic [RATIO_W-1:0] n);
        logic [RATIO_W+1:0] twice;
        logic [RATIO_W+1:0] pw2;
        twice = {1'b0, n, 1'b0};
        pw2   = {{(RATIO_W+1){1'b0}}, 1'b1};
        for (int i = 0; i < RATIO_W; i++) begin
            if (({{(RATIO_W-1){1'b0}}, 3'h3} << i) <= twice) begin
                pw2 = {{(RATIO_W+1){1'b0}}, 1'b1} << i;
            end
        end
        return n - pw2[RATIO_W-1:0];
    endfunction

    // Address decode used by write response
    function automatic logic is_mapped(input logic [pdrh_pkg::ADDR_W-1:0] a);
        return (a == pdrh_pkg::OFF_RATIO)   || (a == pdrh_pkg::OFF_SHIFT) ||
               (a == pdrh_pkg::OFF_STATUS)  || (a == pdrh_pkg::OFF_CONTROL) ||
               (a == pdrh_pkg::OFF_COUNT);
    endfunction

    //------------------------------------------------------------------------
    // Combined controls and edges
    //------------------------------------------------------------------------
    logic core_reset;
    logic core_freeze;
    logic in_edge;
    logic sclk_edge;
    logic load_edge;
    logic do_write;
    logic do_read;

    // Pin and software controls combine
    assign core_reset  = rst_pin | st.control[pdrh_pkg::CTL_RESET_BIT];
    assign core_freeze = frz_pin | st.control[pdrh_pkg::CTL_FREEZE_BIT];
    assign in_edge     = in_lvl & ~st.in_prev;
    assign sclk_edge   = sclk & ~st.sclk_prev;
    assign load_edge   = sload & ~st.load_prev;

    // Bus handshakes
    assign s_axi_awready = ~st.aw_got & ~st.bvalid;
    assign s_axi_wready  = ~st.w_got & ~st.bvalid;
    assign s_axi_arready = ~st.rvalid;
    assign do_read       = s_axi_arvalid & s_axi_arready;
    assign do_write      = (st.aw_got | (s_axi_awvalid & s_axi_awready)) &
                           (st.w_got  | (s_axi_wvalid  & s_axi_wready));

    //------------------------------------------------------------------------
    // Next state
    //------------------------------------------------------------------------
    always_comb begin
        logic [pdrh_pkg::ADDR_W-1:0] wa;
        logic [1:0]                  wctl;
        logic                        wl0;
        logic [RATIO_W-1:0]          cnt_n;
        wa      = st.aw_addr;
        wctl    = st.w_ctl;
        wl0     = st.w_lane0;
        cnt_n   = st.cnt;
        next_st = st;

        // Write address and data, taken in either order
        if (s_axi_awvalid && s_axi_awready) begin
            next_st.aw_got  = 1'b1;
            next_st.aw_addr = s_axi_awaddr;
            wa              = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_st.w_got   = 1'b1;
            next_st.w_ctl   = s_axi_wdata[1:0];
            next_st.w_lane0 = s_axi_wstrb[0];
            wctl            = s_axi_wdata[1:0];
            wl0             = s_axi_wstrb[0];
        end
        if (do_write) begin
            next_st.aw_got = 1'b0;
            next_st.w_got  = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp  = is_mapped(wa) ? pdrh_pkg::RESP_OKAY : pdrh_pkg::RESP_SLVERR;
            if (wa == pdrh_pkg::OFF_CONTROL && wl0) begin
                next_st.control = wctl;
            end
        end else if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end

        // Read path
        if (do_read) begin
            next_st.rvalid = 1'b1;
            next_st.rresp  = pdrh_pkg::RESP_OKAY;
            next_st.rdata  = '0;
            unique case (s_axi_araddr)
                pdrh_pkg::OFF_RATIO:   next_st.rdata = st.ratio;
                pdrh_pkg::OFF_SHIFT:   next_st.rdata = st.shift_img;
                pdrh_pkg::OFF_COUNT:   next_st.rdata = st.cnt;
                pdrh_pkg::OFF_CONTROL: next_st.rdata[1:0] = st.control;
                pdrh_pkg::OFF_STATUS: begin
                    next_st.rdata[pdrh_pkg::STA_RESET_BIT]  = core_reset;
                    next_st.rdata[pdrh_pkg::STA_FREEZE_BIT] = core_freeze;
                    next_st.rdata[pdrh_pkg::STA_POS_BIT]    = st.out_pos;
                    next_st.rdata[pdrh_pkg::STA_NEG_BIT]    = st.out_neg;
                end
                default: next_st.rresp = pdrh_pkg::RESP_SLVERR;
            endcase
        end else if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end

        // Serial link: shift MSB first, weights by bit index
        next_st.sclk_prev = sclk;
        next_st.load_prev = sload;
        if (sclk_edge) begin
            next_st.shift_img = {st.shift_img[RATIO_W-2:0], sdat};
        end
        // Ratio changes only on strobe, whatever reset or freeze do
        if (load_edge) begin
            next_st.ratio   = st.shift_img;
            next_st.pulse_w = pulse_width(st.shift_img);
        end

        // Divider core counts input cycles modulo N
        next_st.in_prev = in_lvl;
        if (in_edge) begin
            if (st.ratio == '0 || st.cnt >= st.ratio - 1'b1) begin
                cnt_n = '0;
            end else begin
                cnt_n = st.cnt + 1'b1;
            end
        end

        if (core_reset) begin
            // Counter cleared, outputs forced and still
            next_st.cnt     = '0;
            next_st.out_pos = 1'b0;
            next_st.out_neg = 1'b1;
        end else begin
            next_st.cnt = cnt_n;
            if (!core_freeze) begin
                // High for the first pulse_w cycles of each period; ratio one follows the input level
                if (st.ratio == {{(RATIO_W-1){1'b0}}, 1'b1}) begin
                    next_st.out_pos = in_lvl;
                end else if (st.ratio == '0) begin
                    // Zero ratio idles low; host freezes meanwhile
                    next_st.out_pos = 1'b0;
                end else begin
                    next_st.out_pos = (cnt_n < st.pulse_w);
                end
                next_st.out_neg = ~next_st.out_pos;
            end
            // Frozen: outputs keep their level
        end

        if (!aresetn) begin
            next_st         = '0;
            next_st.ratio   = pdrh_pkg::RATIO_RESET;
            next_st.pulse_w = '0;
            next_st.control = pdrh_pkg::CONTROL_RESET;
            next_st.out_neg = 1'b1;
        end
    end

    //------------------------------------------------------------------------
    // State register
    //------------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        st <= next_st;
    end

    // Outputs
    assign div_out_pos  = st.out_pos;
    assign div_out_neg  = st.out_neg;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp  = st.bresp;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rdata  = st.rdata;
    assign s_axi_rresp  = st.rresp;

endmodule

`default_nettype wire

// >>> test/pdrh_asserts.sv
// Purpose: Concurrent checks on divider pins and register bus
// Assumes: Pins pass two sync flops and one output register
// Notes:   Bound to every pdrh_top
`timescale 1ns/100ps
`default_nettype none
module pdrh_asserts (
    input wire logic                        aclk,
    input wire logic                        aresetn,
    input wire logic                        div_reset_ctl,
    input wire logic                        output_freeze_ctl,
    input wire logic                        div_out_pos,
    input wire logic                        div_out_neg,
    input wire logic                        s_axi_awvalid,
    input wire logic                        s_axi_awready,
    input wire logic                        s_axi_wvalid,
    input wire logic                        s_axi_wready,
    input wire logic [1:0]                  s_axi_bresp,
    input wire logic                        s_axi_bvalid,
    input wire logic                        s_axi_bready,
    input wire logic                        s_axi_arvalid,
    input wire logic                        s_axi_arready,
    input wire logic [pdrh_pkg::DATA_W-1:0] s_axi_rdata,
    input wire logic                        s_axi_rvalid,
    input wire logic                        s_axi_rready
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // Handshake and pin hold sequences
    sequence wr_taken_s;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rst_held_s;
        div_reset_ctl [*4];
    endsequence
    sequence frz_held_s;
        (output_freeze_ctl && !div_reset_ctl) [*5];
    endsequence

    out_pair_a: assert property (div_out_neg == !div_out_pos)
        else $error("divided outputs not complementary");
    rst_low_a: assert property (rst_held_s |-> !div_out_pos && div_out_neg)
        else $error("reset did not force output levels");
    rst_still_a: assert property (rst_held_s ##1 div_reset_ctl |-> $stable(div_out_pos))
        else $error("output toggled in reset");
    frz_still_a: assert property (frz_held_s |-> $stable(div_out_pos) && $stable(div_out_neg))
        else $error("output moved while frozen");
    wr_resp_a: assert property (wr_taken_s |=> s_axi_bvalid)
        else $error("write response late");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    b_end_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while busy");
endmodule
bind pdrh_top pdrh_asserts chk_u (
    .aclk, .aresetn, .div_reset_ctl, .output_freeze_ctl, .div_out_pos, .div_out_neg,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rvalid, .s_axi_rready
);
`default_nettype wire

// >>> test/pdrh_host.sv
// Purpose: Host controller model for divider pins and serial link
// Assumes: Link clock of 125 ns period, still between frames
// Notes:   High-speed input toggles every four aclk while run is set
`timescale 1ns/100ps
`default_nettype none
module pdrh_host (
    input  wire logic aclk,
    output logic      div_in,
    output logic      div_reset_ctl,
    output logic      output_freeze_ctl,
    output logic      ratio_serial_in,
    output logic      ratio_shift_clk,
    output logic      ratio_load_strobe
);
    logic       run;
    logic [1:0] ph;

    // Lines idle low; hold up while ratio is zero and input static
    initial begin
        {run, ph, div_in, div_reset_ctl} = 5'h00;
        {ratio_serial_in, ratio_shift_clk, ratio_load_strobe} = 3'h0;
        output_freeze_ctl = 1'b1;
    end

    // High-speed input, four aclk per half period
    always @(posedge aclk) begin
        ph <= ph + 2'h1;
        if (run && ph == 2'h3) begin
            div_in <= !div_in;
        end
    end

    // Static control levels
    task automatic set_ctl(input logic rst, input logic frz);
        @(posedge aclk);
        div_reset_ctl <= rst;
        output_freeze_ctl <= frz;
    endtask

    // Shift MSB first, then strobe; data falls to its idle low level
    task automatic load_ratio(input logic [31:0] n);
        for (int i = 31; i >= 0; i--) begin
            ratio_serial_in = n[i];
            #62.5 ratio_shift_clk = 1'b1;
            #62.5 ratio_shift_clk = 1'b0;
        end
        #62.5 ratio_load_strobe = 1'b1;
        ratio_serial_in = 1'b0;
        #62.5 ratio_load_strobe = 1'b0;
    endtask
endmodule
`default_nettype wire

// >>> test/programmable_divider_reset_hold_tb_top.sv
// Purpose: Self-checking bench for the divider with reset and hold
// Assumes: Host model drives pins; bench speaks the register bus
// Notes:   Pulse width counted in high-speed input rises
`timescale 1ns/100ps
`default_nettype none
module programmable_divider_reset_hold_tb_top;
    logic                        aclk, aresetn, div_in, div_reset_ctl, output_freeze_ctl;
    logic                        ratio_serial_in, ratio_shift_clk, ratio_load_strobe;
    logic                        div_out_pos, div_out_neg, s_axi_awvalid, s_axi_awready;
    logic                        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic                        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [pdrh_pkg::ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [pdrh_pkg::DATA_W-1:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]                  s_axi_wstrb;
    logic [1:0]                  s_axi_bresp, s_axi_rresp;
    int                          n_fail, total_checks;
    int                          ns [18] = '{56, 60, 64, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13,
                                             14, 15, 16};

    pdrh_top dut_u (
        .aclk, .aresetn, .div_in, .div_reset_ctl, .output_freeze_ctl, .ratio_serial_in,
        .ratio_shift_clk, .ratio_load_strobe, .div_out_pos, .div_out_neg, .s_axi_awaddr,
        .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
    );
    pdrh_host host_u (
        .aclk, .div_in, .div_reset_ctl, .output_freeze_ctl, .ratio_serial_in,
        .ratio_shift_clk, .ratio_load_strobe
    );

    // 100 MHz clock
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // Compare and count
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Bus write: ready seen at negedge is taken at the next rising edge
    task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [1:0] r);
        logic aw_hs, w_hs, b_hs;
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, s};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        b_hs = 1'b0;
        for (int i = 0; i < 50 && !b_hs; i++) begin
            @(negedge aclk);
            aw_hs = s_axi_awvalid && s_axi_awready;
            w_hs = s_axi_wvalid && s_axi_wready;
            b_hs = s_axi_bvalid === 1'b1;
            r = s_axi_bresp;
            @(posedge aclk);
            if (aw_hs) s_axi_awvalid <= 1'b0;
            if (w_hs) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        check(32'(b_hs), 32'h0000_0001);
    endtask

    // Bus read
    task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar_hs, r_hs;
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        r_hs = 1'b0;
        for (int i = 0; i < 50 && !r_hs; i++) begin
            @(negedge aclk);
            ar_hs = s_axi_arvalid && s_axi_arready;
            r_hs = s_axi_rvalid === 1'b1;
            {d, r} = {s_axi_rdata, s_axi_rresp};
            @(posedge aclk);
            if (ar_hs) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
        check(32'(r_hs), 32'h0000_0001);
    endtask

    // Read and compare with an OKAY response
    task automatic rdc(input logic [4:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        rd(a, d, r);
        check(d, e);
        check(32'(r), 32'(pdrh_pkg::RESP_OKAY));
    endtask

    // Period and pulse width over one full output period
    task automatic measure(input int n);
        int   w, per, p, k;
        logic pp, dp;
        p = 1;
        while (6 * p <= 2 * n) p = p * 2;
        {w, per, k} = '0;
        {pp, dp} = 2'h3;
        for (int i = 0; i < 3000 && k < 3; i++) begin
            @(negedge aclk);
            if (div_out_pos && !pp) k++;
            if (k == 2 && div_in && !dp) begin
                per++;
                if (div_out_pos) w++;
            end
            {pp, dp} = {div_out_pos, div_in};
        end
        check(32'(w), 32'(n - p));
        check(32'(per), 32'(n));
        check(32'(3 * w >= n && 3 * w <= 2 * n), 32'h0000_0001);
        @(posedge aclk);
    endtask

    // Counts and verdict
    task automatic print_verdict();
        $display("Checks: %0d, failures: %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Watchdog
    initial begin
        #500_000;
        n_fail++;
        print_verdict();
    end

    // Main sequence
    initial begin
        logic [31:0] d, c1, st;
        logic [1:0]  r;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        {n_fail, total_checks, aresetn} = '0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        // Reset values, unmapped and read-only places
        rdc(pdrh_pkg::OFF_RATIO, 32'h0000_0000);
        rdc(pdrh_pkg::OFF_STATUS, 32'h0000_000A);
        rd(5'h14, d, r);
        check({d[29:0], r}, {30'h0, pdrh_pkg::RESP_SLVERR});
        wr(5'h14, 32'h0000_0001, 4'hF, r);
        check(32'(r), 32'(pdrh_pkg::RESP_SLVERR));
        wr(pdrh_pkg::OFF_RATIO, 32'hFFFF_FFFF, 4'hF, r);
        rdc(pdrh_pkg::OFF_RATIO, 32'h0000_0000);
        // Ratio sweep: first load under hold, later ones while running
        host_u.run <= 1'b1;
        foreach (ns[i]) begin
            host_u.load_ratio(32'(ns[i]));
            if (i == 0) host_u.set_ctl(1'b0, 1'b0);
            rdc(pdrh_pkg::OFF_RATIO, 32'(ns[i]));
            measure(ns[i]);
        end
        // Hold: outputs still, counter runs, zero and new ratio accepted
        host_u.set_ctl(1'b0, 1'b1);
        repeat (4) @(posedge aclk);
        rd(pdrh_pkg::OFF_STATUS, st, r);
        rd(pdrh_pkg::OFF_COUNT, c1, r);
        repeat (40) @(posedge aclk);
        rd(pdrh_pkg::OFF_COUNT, d, r);
        check(32'(c1 !== d), 32'h0000_0001);
        host_u.load_ratio(32'h0000_0000);
        rdc(pdrh_pkg::OFF_RATIO, 32'h0000_0000);
        rdc(pdrh_pkg::OFF_STATUS, st);
        host_u.load_ratio(32'h0000_0005);
        rdc(pdrh_pkg::OFF_SHIFT, 32'h0000_0005);
        rdc(pdrh_pkg::OFF_RATIO, 32'h0000_0005);
        host_u.set_ctl(1'b0, 1'b0);
        measure(5);
        // Reset pin: state cleared, levels forced, ratio kept
        host_u.set_ctl(1'b1, 1'b0);
        repeat (4) @(posedge aclk);
        @(negedge aclk);
        check(32'({div_out_pos, div_out_neg}), 32'h0000_0001);
        rdc(pdrh_pkg::OFF_COUNT, 32'h0000_0000);
        repeat (40) @(posedge aclk);
        rdc(pdrh_pkg::OFF_COUNT, 32'h0000_0000);
        rdc(pdrh_pkg::OFF_STATUS, 32'h0000_0009);
        rdc(pdrh_pkg::OFF_RATIO, 32'h0000_0005);
        host_u.set_ctl(1'b0, 1'b0);
        measure(5);
        // Software reset and hold through the control register
        wr(pdrh_pkg::OFF_CONTROL, 32'h0000_0001, 4'h1, r);
        wr(pdrh_pkg::OFF_CONTROL, 32'h0000_0000, 4'h2, r);
        rdc(pdrh_pkg::OFF_CONTROL, 32'h0000_0001);
        rdc(pdrh_pkg::OFF_STATUS, 32'h0000_0009);
        wr(pdrh_pkg::OFF_CONTROL, 32'h0000_0002, 4'h1, r);
        rdc(pdrh_pkg::OFF_STATUS, 32'h0000_000A);
        wr(pdrh_pkg::OFF_CONTROL, 32'h0000_0000, 4'h1, r);
        print_verdict();
    end
endmodule
`default_nettype wire
